//--- design/telegram_slave.v
// Slave telegram framer, parser and responder for a half-duplex serial port.
`timescale 1ns/10ps
`default_nettype none
`include "telegram_slave_regs.vh"

// What this block does
// - Respond only to error-free telegrams for us.
// - Broadcast telegrams are acted on, never answered.
// - Eleven bit characters with even parity.
// - Start, length, address, data, check byte order.
// - Baud rate set by configuration, matches master.
// - Wait two character times before responding.
// - Start response within the maximum response time.
// - Inter-character gap at most two characters; not timed after the start and length bytes, abort at 24 idle bit ticks.
// - Length counts address, data and check byte.
// - Text telegram length is ten plus n.
// - Short address format with broadcast bit five.
// - Long address format, zero means broadcast.
// - Echo received address byte unchanged.
// - Check byte is XOR of all bytes.
// - Response uses same telegram type.
// - Parameter block is eight bytes, four words.
// - Process block is four bytes, two words.
// - Text block: id, index, text, process words.
// - Command field in id word bits 12-15.
// - Decode none, read, and three write commands.

module telegram_slave (
	input  wire        mclk_i,
	input  wire        reset_i,
	input  wire        rxd_i,
	input  wire [15:0] baud_div_i,
	input  wire [6:0]  station_addr_i,
	input  wire [15:0] reply_id_i,
	input  wire [15:0] reply_index_i,
	input  wire [31:0] reply_value_i,
	input  wire [15:0] status_word_i,
	input  wire [15:0] out_freq_i,
	output reg         txd_o,
	output reg         tx_en_o,
	output reg         frame_ok_o,
	output reg         frame_bad_o,
	output reg         broadcast_o,
	output reg  [7:0]  frame_len_o,
	output reg  [3:0]  param_cmd_o,
	output reg         cmd_read_o,
	output reg         cmd_wr_word_o,
	output reg         cmd_wr_dword_o,
	output reg         cmd_wr_nv_o,
	output reg  [15:0] param_id_o,
	output reg  [15:0] param_index_o,
	output reg  [31:0] param_value_o,
	output reg  [15:0] control_word_o,
	output reg  [15:0] reference_o
);

	localparam [5:0] S_HUNT = 6'b000001;
	localparam [5:0] S_LEN  = 6'b000010;
	localparam [5:0] S_ADDR = 6'b000100;
	localparam [5:0] S_DATA = 6'b001000;
	localparam [5:0] S_WAIT = 6'b010000;
	localparam [5:0] S_SEND = 6'b100000;

	// ---------------------------------------------------------------
	// Address decoding
	// ---------------------------------------------------------------
	// broadcast per address format
	function is_bcast;
		input [7:0] a;
		begin
			if (a[`ADDR_LONG_BIT])
				is_bcast = (a[`ADDR_LONG_MSB:0] == 7'h00);
			else
				is_bcast = a[`ADDR_BCAST_BIT];
		end
	endfunction

	function is_mine;
		input [7:0] a;
		input [6:0] st;
		begin
			if (a[`ADDR_LONG_BIT])
				is_mine = (a[`ADDR_LONG_MSB:0] == st) && (st != 7'h00);
			else
				is_mine = !a[`ADDR_BCAST_BIT] && (st[6:5] == 2'b00) &&
					(a[`ADDR_SHORT_MSB:0] == st[4:0]) && (st != 7'h00);
		end
	endfunction

	// ---------------------------------------------------------------
	// Bit tick for gaps and transmit
	// ---------------------------------------------------------------
	reg [15:0] tick_cnt_q;
	reg        tick_q;

	always @(posedge mclk_i) begin
		if (reset_i) begin
			tick_cnt_q <= 16'h0000;
			tick_q     <= 1'b0;
		end else if (tick_cnt_q + 16'h0001 >= baud_div_i) begin
			tick_cnt_q <= 16'h0000;
			tick_q     <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 16'h0001;
			tick_q     <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Character receiver
	// ---------------------------------------------------------------
	reg        rx_busy_q;
	reg [15:0] rx_cnt_q;
	reg [3:0]  rx_bit_q;
	reg [9:0]  rx_sh_q;
	reg        rx_stb_q;
	reg [7:0]  rx_byte_q;
	reg        rx_err_q;
	wire [9:0] rx_sh_next = {rxd_i, rx_sh_q[9:1]};

	// The start bit is sampled at its middle so a glitch is not a character.
	always @(posedge mclk_i) begin
		if (reset_i) begin
			rx_busy_q <= 1'b0;
			rx_cnt_q  <= 16'h0000;
			rx_bit_q  <= 4'h0;
			rx_sh_q   <= 10'h000;
			rx_stb_q  <= 1'b0;
			rx_byte_q <= 8'h00;
			rx_err_q  <= 1'b0;
		end else begin
			rx_stb_q <= 1'b0;
			if (!rx_busy_q) begin
				if (!rxd_i && !tx_en_o) begin
					rx_busy_q <= 1'b1;
					rx_cnt_q  <= {1'b0, baud_div_i[15:1]};
					rx_bit_q  <= 4'h0;
				end
			end else if (rx_cnt_q != 16'h0000) begin
				rx_cnt_q <= rx_cnt_q - 16'h0001;
			end else begin
				rx_cnt_q <= baud_div_i - 16'h0001;
				rx_bit_q <= rx_bit_q + 4'h1;
				if (rx_bit_q == 4'h0) begin
					if (rxd_i)
						rx_busy_q <= 1'b0;
				end else begin
					rx_sh_q <= rx_sh_next;
				end
				// even parity and stop bit check
				if (rx_bit_q == `CHAR_LAST_BIT) begin
					rx_busy_q <= 1'b0;
					rx_stb_q  <= 1'b1;
					rx_byte_q <= rx_sh_next[7:0];
					rx_err_q  <= (^rx_sh_next[8:0]) | !rx_sh_next[9];
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Telegram parser and responder
	// ---------------------------------------------------------------
	reg [5:0] state_q;
	reg [7:0] len_q;
	reg [7:0] rem_q;
	reg [7:0] addr_q;
	reg [7:0] idx_q;
	reg [7:0] xor_q;
	reg [7:0] gap_q;
	reg       bad_q;
	reg [7:0] buf_q [0:`MAX_DATA-1];
	reg [10:0] tx_sh_q;
	reg [3:0]  tx_bits_q;
	reg [7:0]  tx_byte;
	reg [7:0]  dpos;
	reg [7:0]  ppos;

	wire [7:0] ndata  = len_q - `LEN_OVERHEAD;
	wire [7:0] proc0  = ndata - `PROC_BYTES;
	wire [7:0] didx   = len_q - rem_q - 8'h01;
	wire [7:0] xor_nx = xor_q ^ rx_byte_q;
	wire       frame_good = !bad_q && !rx_err_q && (xor_nx == 8'h00);
	wire [15:0] pid_rx = {buf_q[0], buf_q[1]};

	// response byte by position and type
	always @* begin
		dpos = idx_q - 8'h03;
		ppos = dpos - proc0;
		tx_byte = 8'h00;
		if (idx_q == 8'h00)
			tx_byte = `START_CHAR;
		else if (idx_q == 8'h01)
			tx_byte = len_q;
		else if (idx_q == 8'h02)
			tx_byte = addr_q;
		else if (idx_q == len_q + 8'h01)
			tx_byte = xor_q;
		else if (dpos >= proc0) begin
			case (ppos[1:0])
				2'd0: tx_byte = status_word_i[15:8];
				2'd1: tx_byte = status_word_i[7:0];
				2'd2: tx_byte = out_freq_i[15:8];
				default: tx_byte = out_freq_i[7:0];
			endcase
		end else if (dpos < `HEAD_BYTES) begin
			case (dpos[1:0])
				2'd0: tx_byte = reply_id_i[15:8];
				2'd1: tx_byte = reply_id_i[7:0];
				2'd2: tx_byte = reply_index_i[15:8];
				default: tx_byte = reply_index_i[7:0];
			endcase
		end else if (len_q == `LEN_PARAM && dpos <= `VALUE_LAST) begin
			case (dpos[1:0])
				2'd0: tx_byte = reply_value_i[31:24];
				2'd1: tx_byte = reply_value_i[23:16];
				2'd2: tx_byte = reply_value_i[15:8];
				default: tx_byte = reply_value_i[7:0];
			endcase
		end else
			tx_byte = buf_q[dpos[`BUF_AW-1:0]];
	end

	always @(posedge mclk_i) begin
		if (didx < `MAX_DATA_BYTE && state_q == S_DATA && rx_stb_q &&
			rem_q != 8'h01)
			buf_q[didx[`BUF_AW-1:0]] <= rx_byte_q;
	end

	always @(posedge mclk_i) begin
		if (reset_i) begin
			state_q        <= S_HUNT;
			len_q          <= 8'h00;
			rem_q          <= 8'h00;
			addr_q         <= 8'h00;
			idx_q          <= 8'h00;
			xor_q          <= `XOR_INIT;
			gap_q          <= 8'h00;
			bad_q          <= 1'b0;
			tx_sh_q        <= 11'h7ff;
			tx_bits_q      <= 4'h0;
			txd_o          <= 1'b1;
			tx_en_o        <= 1'b0;
			frame_ok_o     <= 1'b0;
			frame_bad_o    <= 1'b0;
			broadcast_o    <= 1'b0;
			frame_len_o    <= 8'h00;
			param_cmd_o    <= `CMD_NONE;
			cmd_read_o     <= 1'b0;
			cmd_wr_word_o  <= 1'b0;
			cmd_wr_dword_o <= 1'b0;
			cmd_wr_nv_o    <= 1'b0;
			param_id_o     <= 16'h0000;
			param_index_o  <= 16'h0000;
			param_value_o  <= 32'h00000000;
			control_word_o <= 16'h0000;
			reference_o    <= 16'h0000;
		end else begin
			frame_ok_o     <= 1'b0;
			frame_bad_o    <= 1'b0;
			cmd_read_o     <= 1'b0;
			cmd_wr_word_o  <= 1'b0;
			cmd_wr_dword_o <= 1'b0;
			cmd_wr_nv_o    <= 1'b0;
			if (rx_stb_q)
				gap_q <= 8'h00;
			else if (tick_q && !rx_busy_q)
				gap_q <= gap_q + 8'h01;
			case (state_q)
			S_HUNT: begin
				// resync on start char, XOR from zero
				if (rx_stb_q && !rx_err_q && rx_byte_q == `START_CHAR) begin
					xor_q   <= `XOR_INIT ^ rx_byte_q;
					bad_q   <= 1'b0;
					state_q <= S_LEN;
				end
			end
			S_LEN: begin
				if (rx_stb_q) begin
					// length counts the bytes still to come
					len_q   <= rx_byte_q;
					rem_q   <= rx_byte_q;
					xor_q   <= xor_nx;
					bad_q   <= bad_q | rx_err_q | (rx_byte_q < `LEN_MIN) |
						(rx_byte_q - `LEN_OVERHEAD > `MAX_DATA_BYTE);
					state_q <= S_ADDR;
				end
			end
			S_ADDR: begin
				if (rx_stb_q) begin
					addr_q  <= rx_byte_q;
					rem_q   <= rem_q - 8'h01;
					xor_q   <= xor_nx;
					bad_q   <= bad_q | rx_err_q;
					state_q <= S_DATA;
				end
			end
			S_DATA: begin
				if (rx_stb_q) begin
					rem_q <= rem_q - 8'h01;
					xor_q <= xor_nx;
					bad_q <= bad_q | rx_err_q;
					// last counted byte is the check byte
					if (rem_q == 8'h01) begin
						gap_q   <= 8'h00;
						xor_q   <= `XOR_INIT;
						idx_q   <= 8'h00;
						state_q <= S_HUNT;
						// any error discards the telegram silently
						if (!frame_good)
							frame_bad_o <= 1'b1;
						else if (is_bcast(addr_q) || is_mine(addr_q,
							station_addr_i)) begin
							frame_ok_o  <= 1'b1;
							broadcast_o <= is_bcast(addr_q);
							frame_len_o <= len_q;
							control_word_o <= {buf_q[proc0[`BUF_AW-1:0]],
								buf_q[proc0[`BUF_AW-1:0] + 1'b1]};
							reference_o <= {buf_q[proc0[`BUF_AW-1:0] + 2'd2],
								buf_q[proc0[`BUF_AW-1:0] + 2'd3]};
							if (len_q > `LEN_MIN) begin
								param_id_o    <= pid_rx;
								param_cmd_o   <= pid_rx[`CMD_MSB:`CMD_LSB];
								param_index_o <= {buf_q[2], buf_q[3]};
								cmd_read_o    <= pid_rx[`CMD_MSB:`CMD_LSB] ==
									`CMD_READ;
								cmd_wr_word_o <= pid_rx[`CMD_MSB:`CMD_LSB] ==
									`CMD_WR_WORD;
								cmd_wr_dword_o <= pid_rx[`CMD_MSB:`CMD_LSB] ==
									`CMD_WR_DWORD;
								cmd_wr_nv_o   <= pid_rx[`CMD_MSB:`CMD_LSB] ==
									`CMD_WR_DWORD_NV;
							end
							// value words only in parameter telegrams
							if (len_q == `LEN_PARAM)
								param_value_o <= {buf_q[4], buf_q[5],
									buf_q[6], buf_q[7]};
							if (!is_bcast(addr_q))
								state_q <= S_WAIT;
						end
					end
				end else if (gap_q >= `GAP_ABORT_BITS) begin
					// gap too long drops the telegram
					frame_bad_o <= 1'b1;
					state_q     <= S_HUNT;
				end
			end
			S_WAIT: begin
				// pause two characters, then answer at once
				if (gap_q >= `RESP_GAP_BITS) begin
					tx_en_o <= 1'b1;
					state_q <= S_SEND;
				end
			end
			S_SEND: begin
				if (tick_q) begin
					if (tx_bits_q != 4'h0) begin
						txd_o     <= tx_sh_q[0];
						tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
						tx_bits_q <= tx_bits_q - 4'h1;
					end else if (idx_q != len_q + `LEN_OVERHEAD) begin
						txd_o     <= 1'b0;
						tx_sh_q   <= {2'b11, ^tx_byte, tx_byte};
						tx_bits_q <= `CHAR_DATA_BITS;
						xor_q     <= xor_q ^ tx_byte;
						idx_q     <= idx_q + 8'h01;
					end else begin
						// release after the last stop bit
						tx_en_o <= 1'b0;
						txd_o   <= 1'b1;
						gap_q   <= 8'h00;
						state_q <= S_HUNT;
					end
				end
			end
			default: state_q <= S_HUNT;
			endcase
		end
	end

endmodule
`default_nettype wire

//--- design/telegram_slave_regs.vh
// Constants for the serial telegram slave: characters, framing and timing.
`ifndef TELEGRAM_SLAVE_REGS_VH
`define TELEGRAM_SLAVE_REGS_VH

// ---------------------------------------------------------------
// Character and telegram framing
// ---------------------------------------------------------------
`define START_CHAR       8'h02
`define CHAR_LAST_BIT    4'ha
`define CHAR_DATA_BITS   4'ha
`define LEN_MIN          8'h06
`define LEN_PARAM        8'h0e
`define LEN_OVERHEAD     8'h02
`define TEXT_FIXED_LEN   8'h0a
`define PROC_BYTES       8'h04
`define HEAD_BYTES       8'h04
`define VALUE_LAST       8'h07
`define MAX_DATA         64
`define MAX_DATA_BYTE    8'h40
`define BUF_AW           6
`define XOR_INIT         8'h00

// ---------------------------------------------------------------
// Address byte layout
// ---------------------------------------------------------------
`define ADDR_LONG_BIT    7
`define ADDR_BCAST_BIT   5
`define ADDR_SHORT_MSB   4
`define ADDR_LONG_MSB    6

// ---------------------------------------------------------------
// Parameter command field in the parameter id word
// ---------------------------------------------------------------
`define CMD_MSB          15
`define CMD_LSB          12
`define CMD_NONE         4'h0
`define CMD_READ         4'h1
`define CMD_WR_WORD      4'h2
`define CMD_WR_DWORD     4'h3
`define CMD_WR_DWORD_NV  4'hd

// ---------------------------------------------------------------
// Timing: gaps in bit times of the configured baud rate, response limit in ms
// ---------------------------------------------------------------
`define CHAR_BITS        8'd11
`define PAUSE_CHARS      8'd2
`define PAUSE_BITS       (`CHAR_BITS * `PAUSE_CHARS)
`define GAP_ABORT_BITS   (`PAUSE_BITS + 8'd2)
`define RESP_GAP_BITS    (`PAUSE_BITS + 8'd1)
`define RESP_MAX_MS      20
`define CLK_MHZ          100
`define RESP_MAX_CYCLES  (`RESP_MAX_MS * 1000 * `CLK_MHZ)

`endif

//--- sim/master_model.sv
// Behavioural bus master that polls the slave over the serial line.
`timescale 1ns/10ps
`default_nettype none
module master_model #(parameter int DIV = 8) (
	input  wire logic mclk_i,
	input  wire logic line_i,
	input  wire logic drv_en_i,
	output var  logic line_o
);
	logic [7:0] fb [0:31];
	logic [7:0] rq [$];
	int         n_badc = 0;
	initial line_o = 1'b1;
	task automatic put_char(input logic [7:0] b, input logic flip);
		logic [10:0] c;
		c = {1'b1, ^b ^ flip, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			line_o = c[i];
			repeat (DIV) @(negedge mclk_i);
		end
	endtask
	task automatic send(input int n, input int perr, input int gap);
		wait (!drv_en_i);
		repeat (24 * DIV) @(negedge mclk_i);
		rq.delete();
		for (int i = 0; i < n; i++) begin
			if (i == gap)
				repeat (30 * DIV) @(negedge mclk_i);
			put_char(fb[i], i == perr);
		end
	endtask
	always begin
		logic [9:0] s;
		@(negedge line_i iff drv_en_i);
		repeat (DIV / 2) @(posedge mclk_i);
		for (int i = 0; i < 10; i++) begin
			repeat (DIV) @(posedge mclk_i);
			s[i] = line_i;
		end
		if (!s[9] || ^s[8:0])
			n_badc++;
		rq.push_back(s[7:0]);
	end
endmodule
`default_nettype wire

//--- sim/slave_chk.sv
// Concurrent checks on the telegram slave ports.
`timescale 1ns/10ps
`default_nettype none
module slave_chk (
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	input  wire logic [15:0] baud_div_i,
	input  wire logic        txd_o,
	input  wire logic        tx_en_o,
	input  wire logic        frame_ok_o,
	input  wire logic        frame_bad_o,
	input  wire logic        broadcast_o,
	input  wire logic [3:0]  param_cmd_o,
	input  wire logic        cmd_read_o,
	input  wire logic        cmd_wr_nv_o
);
	logic [19:0] since_ok_q;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	// Saturates, so that a stale acceptance never looks recent again.
	always_ff @(posedge mclk_i) begin
		if (reset_i)
			since_ok_q <= 20'hfffff;
		else if (frame_ok_o)
			since_ok_q <= 20'h00000;
		else if (since_ok_q != 20'hfffff)
			since_ok_q <= since_ok_q + 20'h00001;
	end
	a_line_idle: assert property (!tx_en_o |-> txd_o)
		else $error("line not idle with driver off");
	a_ok_bad_apart: assert property (!(frame_ok_o && frame_bad_o))
		else $error("accept and discard together");
	a_ok_single: assert property (frame_ok_o |=> !frame_ok_o)
		else $error("accept pulse too long");
	a_read_decode: assert property (
		cmd_read_o |-> frame_ok_o && param_cmd_o == 4'h1)
		else $error("read strobe without read command");
	a_nv_decode: assert property (
		cmd_wr_nv_o |-> frame_ok_o && param_cmd_o == 4'hd)
		else $error("nonvolatile strobe without its command");
	a_bcast_silent: assert property ($rose(tx_en_o) |-> !broadcast_o)
		else $error("reply to a broadcast");
	a_resp_cause: assert property (
		$rose(tx_en_o) |-> since_ok_q < 20'd1000)
		else $error("reply without accepted telegram");
	a_resp_pause: assert property (
		$rose(tx_en_o) |-> since_ok_q >= 21 * baud_div_i)
		else $error("reply pause too short");
	a_resp_bound: assert property (
		frame_ok_o ##1 !broadcast_o |-> ##[0:999] tx_en_o)
		else $error("reply late");
	a_stop_last: assert property ($fell(tx_en_o) |-> $past(txd_o))
		else $error("driver off before stop bit");
endmodule
bind telegram_slave slave_chk u_chk (.mclk_i(mclk_i), .reset_i(reset_i),
	.baud_div_i(baud_div_i), .txd_o(txd_o), .tx_en_o(tx_en_o),
	.frame_ok_o(frame_ok_o), .frame_bad_o(frame_bad_o),
	.broadcast_o(broadcast_o), .param_cmd_o(param_cmd_o),
	.cmd_read_o(cmd_read_o), .cmd_wr_nv_o(cmd_wr_nv_o));
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the telegram slave.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	localparam int DIV = 8;
	logic        mclk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        rxd_i;
	logic [15:0] baud_div_i = 16'h0008;
	logic [6:0]  station_addr_i = 7'h05;
	logic [15:0] reply_id_i = 16'h0000, reply_index_i = 16'h0000;
	logic [15:0] status_word_i = 16'h0000, out_freq_i = 16'h0000;
	logic [31:0] reply_value_i = 32'h00000000;
	logic        txd_o, tx_en_o, frame_ok_o, frame_bad_o, broadcast_o;
	logic        cmd_read_o, cmd_wr_word_o, cmd_wr_dword_o, cmd_wr_nv_o;
	logic [7:0]  frame_len_o;
	logic [3:0]  param_cmd_o, cmd_seen;
	logic [15:0] param_id_o, param_index_o, control_word_o, reference_o;
	logic [31:0] param_value_o;
	logic [3:0]  cmds [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hd};
	logic [7:0]  lens [3] = '{8'h06, 8'h0d, 8'h0e};
	int          seed = 6572;
	int          err_total = 0;
	int          n_compared = 0;
	int          n_ok = 0;
	int          n_bad = 0;
	always #5 mclk_i = ~mclk_i;
	telegram_slave dut (.*);
	master_model #(.DIV(DIV)) m (.mclk_i(mclk_i), .line_i(txd_o),
		.drv_en_i(tx_en_o), .line_o(rxd_i));
	always @(posedge mclk_i) begin
		if (frame_ok_o === 1'b1) begin
			n_ok <= n_ok + 1;
			cmd_seen <= {cmd_read_o, cmd_wr_word_o, cmd_wr_dword_o, cmd_wr_nv_o};
		end
		if (frame_bad_o === 1'b1)
			n_bad <= n_bad + 1;
	end
	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [3:0] dec(input logic [3:0] c);
		return {c == 4'h1, c == 4'h2, c == 4'h3, c == 4'hd};
	endfunction
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Kind 0 is clean, 1 bad parity, 2 bad check byte, 3 long gap.
	task automatic run(input logic [7:0] adr, input logic [7:0] len,
			input logic [3:0] cmd, input int kind, input bit acc, input bit ans);
		logic [7:0] e [0:31];
		logic [7:0] x;
		int n, ok0, bad0;
		n = len + 2;
		@(negedge mclk_i);
		reply_id_i = $random(seed);
		reply_index_i = $random(seed);
		reply_value_i = $random(seed);
		status_word_i = $random(seed);
		out_freq_i = $random(seed);
		m.fb[0] = 8'h02;
		m.fb[1] = len;
		m.fb[2] = adr;
		for (int i = 3; i < n - 1; i++)
			m.fb[i] = $random(seed);
		if (len > 8'h06)
			m.fb[3][7:4] = cmd;
		x = 8'h00;
		for (int i = 0; i < n - 1; i++)
			x ^= m.fb[i];
		m.fb[n - 1] = x ^ {7'h00, kind == 2};
		ok0 = n_ok;
		bad0 = n_bad;
		m.send(n, kind == 1 ? 4 : 99, kind == 3 ? 5 : 99);
		repeat (DIV) @(negedge mclk_i);
		check("accepted", n_ok - ok0, acc);
		check("discarded", n_bad - bad0, kind != 0);
		for (int t = 0; t < 40 * DIV && !tx_en_o; t++)
			@(negedge mclk_i);
		for (int t = 0; t < 220 * DIV && tx_en_o; t++)
			@(negedge mclk_i);
		check("reply size", m.rq.size(), ans ? n : 0);
		check("reply chars", m.n_badc, 0);
		if (acc) begin
			check("length", frame_len_o, len);
			check("broadcast", broadcast_o, !ans);
			check("process", {control_word_o, reference_o},
				{m.fb[n-5], m.fb[n-4], m.fb[n-3], m.fb[n-2]});
			if (len > 8'h06)
				check("command", {param_cmd_o, cmd_seen}, {cmd, dec(cmd)});
			if (len > 8'h06)
				check("id", {param_id_o, param_index_o},
					{m.fb[3], m.fb[4], m.fb[5], m.fb[6]});
			if (len == 8'h0e)
				check("value", param_value_o,
					{m.fb[7], m.fb[8], m.fb[9], m.fb[10]});
		end
		if (ans) begin
			for (int i = 0; i < n; i++)
				e[i] = m.fb[i];
			if (len > 8'h06)
				{e[3], e[4], e[5], e[6]} = {reply_id_i, reply_index_i};
			if (len == 8'h0e)
				{e[7], e[8], e[9], e[10]} = reply_value_i;
			{e[n-5], e[n-4], e[n-3], e[n-2]} = {status_word_i, out_freq_i};
			x = 8'h00;
			for (int i = 0; i < n - 1; i++)
				x ^= e[i];
			e[n - 1] = x;
			for (int i = 0; i < n && i < m.rq.size(); i++)
				check("reply byte", m.rq[i], e[i]);
		end
		$display("test adr %h len %h kind %0d done", adr, len, kind);
	endtask
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (3) @(negedge mclk_i);
		reset_i = 1'b0;
		check("txd idle", txd_o, 1'b1);
		check("driver off", tx_en_o, 1'b0);
		check("length reset", frame_len_o, 8'h00);
		// every command in a parameter telegram
		foreach (cmds[i])
			run(8'h05, 8'h0e, cmds[i], 0, 1, 1);
		// address formats and a text telegram
		run(8'h45, 8'h06, 4'h0, 0, 1, 1);
		run(8'h85, 8'h0d, 4'h1, 0, 1, 1);
		run(8'h7a, 8'h0e, 4'h3, 0, 1, 0);
		run(8'h80, 8'h0d, 4'h2, 0, 1, 0);
		run(8'h06, 8'h06, 4'h0, 0, 0, 0);
		run(8'h86, 8'h0e, 4'h1, 0, 0, 0);
		// discarded telegrams, then a clean one
		run(8'h05, 8'h0e, 4'h1, 1, 0, 0);
		run(8'h05, 8'h0e, 4'h2, 2, 0, 0);
		run(8'h05, 8'h06, 4'h0, 3, 0, 0);
		run(8'h05, 8'h0e, 4'h3, 0, 1, 1);
		repeat (3)
			run(8'h85, lens[$unsigned($random(seed)) % 3],
				cmds[$unsigned($random(seed)) % 5], 0, 1, 1);
		final_report();
	end
	initial begin
		#1_000_000;
		err_total++;
		final_report();
	end
endmodule
`default_nettype wire
